//--- rtl/charge_time_measure_ctrl.v
// Purpose: Control logic of the charge/time measurement unit
// Assumes: AHB-Lite slave, single-word transfers, zero wait states
// Notes: Analog source, converter and comparator stay outside
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`include "ctu_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module charge_time_measure_ctrl
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire edge_pin_one,
    input wire edge_pin_two,
    input wire event_trigger_one,
    input wire event_trigger_two,
    input wire comparator_two_out,
    output reg source_enable,
    output reg [1:0] current_range_sel,
    output reg [5:0] current_trim,
    output reg discharge_enable,
    output reg delay_mode_select,
    output reg delay_pulse,
    output reg conversion_start,
    output reg measure_irq
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg [7:0] control_high;
    reg [7:0] edge_low;
    reg [1:0] irq_reg;
    reg wr_pend;
    reg [7:0] wr_addr;
    reg source_prev;

    wire module_enable = control_high[`HI_MODULE_EN];
    wire edge_inputs_enable = control_high[`HI_EDGE_EN];
    wire edge_order_enable = control_high[`HI_ORDER];
    wire conversion_trigger_enable = control_high[`HI_TRIGGER];
    wire edge_one_status = edge_low[`LO_STAT1];
    wire edge_two_status = edge_low[`LO_STAT2];
    wire [1:0] edge_one_source = edge_low[`LO_SRC1_LSB+1:`LO_SRC1_LSB];
    wire [1:0] edge_two_source = edge_low[`LO_SRC2_LSB+1:`LO_SRC2_LSB];

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    wire [4:0] raw_in = {comparator_two_out, event_trigger_two, event_trigger_one,
                         edge_pin_two, edge_pin_one};
    wire [4:0] syn_in;
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_sync
            level_sync u_sync
            (
                .hclk(hclk),
                .hresetn(hresetn),
                .async_in(raw_in[gi]),
                .sync_out(syn_in[gi])
            );
        end
    endgenerate

    wire [3:0] sources = syn_in[3:0];
    wire hit_one;
    wire hit_two;

    edge_source_mux u_mux_one
    (
        .sources(sources),
        .select(edge_one_source),
        .polarity(edge_low[`LO_POL1]),
        .hit(hit_one)
    );

    edge_source_mux u_mux_two
    (
        .sources(sources),
        .select(edge_two_source),
        .polarity(edge_low[`LO_POL2]),
        .hit(hit_two)
    );

    // ------------------------------------------------------------------
    // Edge event qualification
    // ------------------------------------------------------------------
    // gate on edge enable
    wire ev_one = module_enable & edge_inputs_enable & hit_one;
    wire ev_two = module_enable & edge_inputs_enable & hit_two &
                  (~edge_order_enable | edge_one_status);

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    wire take = hsel & hready & (htrans == `HTRANS_NONSEQ);
    wire do_wr = wr_pend;
    wire wr_hi = do_wr & (wr_addr == `OFS_CONTROL_HIGH);
    wire wr_lo = do_wr & (wr_addr == `OFS_EDGE_LOW);
    wire wr_cur = do_wr & (wr_addr == `OFS_CURRENT);
    wire wr_irq = do_wr & (wr_addr == `OFS_IRQ);

    reg [7:0] next_edge_low;
    reg [7:0] read_mux;

    always @*
    begin
        next_edge_low = edge_low;
        if (wr_lo)
        begin
            // write zeros clears; write one sets edge one
            next_edge_low = hwdata[7:0];
        end
        if (ev_one)
        begin
            next_edge_low[`LO_STAT1] = 1'b1;
        end
        if (ev_two)
        begin
            next_edge_low[`LO_STAT2] = 1'b1;
        end
    end

    always @*
    begin
        case (haddr)
            `OFS_CONTROL_HIGH: read_mux = control_high;
            `OFS_EDGE_LOW: read_mux = edge_low;
            `OFS_CURRENT: read_mux = {current_trim, current_range_sel};
            `OFS_IRQ: read_mux = {6'h00, irq_reg};
            default: read_mux = 8'h00;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            wr_pend <= take & hwrite;
            if (take)
            begin
                wr_addr <= haddr;
            end
            if (take & ~hwrite)
            begin
                hrdata <= {24'h000000, read_mux};
            end
        end
    end

    // ------------------------------------------------------------------
    // Control and status registers
    // ------------------------------------------------------------------
    wire next_source = edge_one_status ^ edge_two_status;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            control_high <= `RST_CONTROL_HIGH;
            edge_low <= `RST_EDGE_LOW;
            current_range_sel <= 2'h0;
            current_trim <= 6'h00;
            irq_reg <= `RST_IRQ;
            source_prev <= 1'b0;
        end
        else
        begin
            if (wr_hi)
            begin
                control_high <= hwdata[7:0];
            end
            edge_low <= next_edge_low;
            if (wr_cur)
            begin
                current_range_sel <= hwdata[1:0];
                current_trim <= hwdata[7:2];
            end
            source_prev <= next_source;
            if (source_prev & ~next_source)
            begin
                irq_reg[`IRQ_FLAG] <= 1'b1;
            end
            else if (wr_irq & ~hwdata[`IRQ_FLAG])
            begin
                irq_reg[`IRQ_FLAG] <= 1'b0;
            end
            if (wr_irq)
            begin
                irq_reg[`IRQ_ENABLE] <= hwdata[`IRQ_ENABLE];
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs to the analog side and the interrupt output
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            source_enable <= 1'b0;
            discharge_enable <= 1'b0;
            delay_mode_select <= 1'b0;
            delay_pulse <= 1'b0;
            conversion_start <= 1'b0;
            measure_irq <= 1'b0;
        end
        else
        begin
            source_enable <= module_enable & (edge_one_status ^ edge_two_status);
            discharge_enable <= control_high[`HI_DISCHARGE];
            delay_mode_select <= control_high[`HI_DELAY_MODE];
            delay_pulse <= module_enable & control_high[`HI_DELAY_MODE] &
                           edge_one_status & ~syn_in[4];
            conversion_start <= conversion_trigger_enable & ev_two & ~edge_two_status;
            measure_irq <= irq_reg[`IRQ_FLAG] & irq_reg[`IRQ_ENABLE];
        end
    end
endmodule // charge_time_measure_ctrl
`default_nettype wire

//--- rtl/ctu_consts.vh
// Purpose: Constants of the charge/time unit control block
// Assumes: AHB-Lite register slave, 32-bit words
// Notes: Register offsets are byte addresses
//
// What this block does
// - Current range select held in current control bits 1:0.
// - Six-bit current trim held in current control bits 7:2.
// - Source select per edge: edge one bits 3:2, edge two bits 6:5 low.
// - Polarity bit per edge, bit 4 and bit 7, default negative polarity.
// - Edge ordering enable at high register bit 2, cleared after reset.
// - Mode bit chooses measurement or time delay; measurement by default.
// - Trigger bit set starts a conversion on the second edge event.
// - Discharge bit set drives the circuit to discharge until cleared.
// - High register bit 7 gates the source, edge events and delay pulse; discharge is not gated.
// - Software clears both edge status bits by writing zeros.
// - Edge events are accepted only while edge input enable is set.
// - Software writing edge-one status to one turns the source on.
// - Each edge takes its source from a pin or a special event trigger.
// - Delay mode ends its output pulse by the second comparator.
// - Source is on only while exactly one edge status bit is set.
// - Status bit sets when its channel shows the selected polarity level.
// - Flag sets when the source goes from on to off; interrupt if enabled.
// - Trim is signed: zero neutral, 100000 most negative, 011111 most positive.
`ifndef CTU_CONSTS_VH
`define CTU_CONSTS_VH

`define OFS_CONTROL_HIGH 8'h00
`define OFS_EDGE_LOW 8'h04
`define OFS_CURRENT 8'h08
`define OFS_IRQ 8'h0C

`define RST_CONTROL_HIGH 8'h00
`define RST_EDGE_LOW 8'h00
`define RST_CURRENT 8'h00
`define RST_IRQ 2'h0

`define HI_TRIGGER 0
`define HI_DISCHARGE 1
`define HI_ORDER 2
`define HI_EDGE_EN 3
`define HI_DELAY_MODE 4
`define HI_MODULE_EN 7

`define LO_STAT1 0
`define LO_STAT2 1
`define LO_SRC1_LSB 2
`define LO_POL1 4
`define LO_SRC2_LSB 5
`define LO_POL2 7

`define IRQ_FLAG 0
`define IRQ_ENABLE 1

`define HTRANS_NONSEQ 2'h2

`endif

//--- rtl/level_sync.v
// Purpose: Two flip-flop synchroniser for one level
// Assumes: Input is asynchronous to hclk
// Notes: First stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module level_sync
(
    input wire hclk,
    input wire hresetn,
    input wire async_in,
    output reg sync_out
);
    reg meta;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // level_sync
`default_nettype wire

//--- rtl/edge_source_mux.v
// Purpose: Pick one of four edge sources and apply polarity
// Assumes: Sources already on hclk
// Notes: Polarity 0 responds to a low level
`timescale 1ns/1ns
`default_nettype none
module edge_source_mux
(
    input wire [3:0] sources,
    input wire [1:0] select,
    input wire polarity,
    output wire hit
);
    assign hit = polarity ? sources[select] : ~sources[select];
endmodule // edge_source_mux
`default_nettype wire

//--- bench/ctu_chk.sv
// Purpose: Port checker for charge_time_measure_ctrl
// Assumes: Zero wait state slave
// Notes: Shadows registers from bus writes
`include "ctu_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module ctu_chk
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire source_enable,
    input wire [1:0] current_range_sel,
    input wire [5:0] current_trim,
    input wire discharge_enable,
    input wire delay_mode_select,
    input wire delay_pulse,
    input wire conversion_start,
    input wire measure_irq
);
// ----
// Register shadow
// ----
reg wr_dp;
reg [7:0] wr_a;
reg [7:0] hi;
reg [7:0] cur;
reg [2:0] age;
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        wr_dp <= 1'b0;
        wr_a <= 8'h00;
        hi <= 8'h00;
        cur <= 8'h00;
        age <= 3'h7;
    end
    else
    begin
        wr_dp <= hsel && hready && htrans == `HTRANS_NONSEQ && hwrite;
        wr_a <= haddr;
        if (wr_dp && wr_a == `OFS_CONTROL_HIGH)
            hi <= hwdata[7:0];
        if (wr_dp && wr_a == `OFS_CURRENT)
            cur <= hwdata[7:0];
        if (wr_dp)
            age <= 3'h0;
        else if (age != 3'h7)
            age <= age + 3'h1;
    end
end
// ----
// Assertions
// ----
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
a_range_trim: assert property (age > 3'h3 |-> current_range_sel == cur[1:0] && current_trim == cur[7:2])
    else $error("range or trim output wrong");
a_discharge_out: assert property (age > 3'h3 |-> discharge_enable == hi[`HI_DISCHARGE])
    else $error("discharge output wrong");
a_mode_out: assert property (age > 3'h3 |-> delay_mode_select == hi[`HI_DELAY_MODE])
    else $error("mode output wrong");
a_unit_off: assert property (age > 3'h3 && !hi[`HI_MODULE_EN] |-> !source_enable)
    else $error("source on while unit disabled");
a_trig_off: assert property (age > 3'h3 && !hi[`HI_TRIGGER] |-> !conversion_start)
    else $error("conversion without trigger enable");
a_trig_pulse: assert property (conversion_start |=> !conversion_start)
    else $error("conversion start too long");
a_irq_cause: assert property ($rose(measure_irq) |-> !source_enable)
    else $error("irq while source on");
a_pulse_mode: assert property (age > 3'h3 && !hi[`HI_DELAY_MODE] |-> !delay_pulse)
    else $error("delay pulse outside delay mode");
a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
a_read_upper: assert property (hrdata[31:8] == 24'h000000)
    else $error("read upper bits set");
c_source: cover property ($rose(source_enable));
c_convert: cover property (conversion_start);
c_irq: cover property ($rose(measure_irq));
c_pulse_end: cover property ($fell(delay_pulse));
endmodule // ctu_chk
bind charge_time_measure_ctrl ctu_chk ctu_chk_inst
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .source_enable(source_enable), .current_range_sel(current_range_sel), .current_trim(current_trim),
    .discharge_enable(discharge_enable), .delay_mode_select(delay_mode_select), .delay_pulse(delay_pulse),
    .conversion_start(conversion_start), .measure_irq(measure_irq)
);
`default_nettype wire

//--- bench/analog_side_model.sv
// Purpose: Current source, capacitor, comparator and converter
// Assumes: Charge counts up one per cycle
// Notes: Threshold is arbitrary
`timescale 1ns/1ns
`default_nettype none
module analog_side_model
#(
    parameter THRESH = 8'h05
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic source_enable,
    input wire logic discharge_enable,
    input wire logic conversion_start,
    output logic comparator_two_out,
    output logic [7:0] conv_count
);
logic [7:0] charge;
assign comparator_two_out = charge >= THRESH;
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        charge <= 8'h00;
        conv_count <= 8'h00;
    end
    else
    begin
        if (discharge_enable)
            charge <= 8'h00;
        else if (source_enable && charge != 8'hFF)
            charge <= charge + 8'h01;
        if (conversion_start)
            conv_count <= conv_count + 8'h01;
    end
end
endmodule // analog_side_model
`default_nettype wire

//--- bench/tb_charge_time_measure_ctrl.sv
// Purpose: Self-checking bench for charge_time_measure_ctrl
// Assumes: hclk 25 MHz, zero wait state bus
// Notes: Reads checked by a queue monitor
`include "ctu_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module tb_charge_time_measure_ctrl;
logic hclk, hresetn, hsel, hwrite, e1, e2, t1, t2, rd_dp;
logic [7:0] haddr, r;
logic [1:0] htrans;
logic [2:0] hsize;
logic [31:0] hwdata;
wire [31:0] hrdata;
wire hreadyout, hresp, src, dis, dmode, conv, irq, cmp, pulse;
wire [1:0] rng;
wire [5:0] trim;
wire [7:0] convs;
logic [7:0] exp_q[$];
integer seed, failures, samples_checked, cycles;
charge_time_measure_ctrl charge_time_measure_ctrl_inst
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .edge_pin_one(e1), .edge_pin_two(e2), .event_trigger_one(t1), .event_trigger_two(t2),
    .comparator_two_out(cmp), .source_enable(src), .current_range_sel(rng), .current_trim(trim),
    .discharge_enable(dis), .delay_mode_select(dmode), .delay_pulse(pulse), .conversion_start(conv),
    .measure_irq(irq)
);
analog_side_model analog_side_model_inst
(
    .hclk(hclk), .hresetn(hresetn), .source_enable(src), .discharge_enable(dis),
    .conversion_start(conv), .comparator_two_out(cmp), .conv_count(convs)
);
initial
begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
end
task chk(input string nm, input [7:0] e, input [7:0] g);
begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
        failures = failures + 1;
        $display("BAD %s exp %h got %h", nm, e, g);
    end
end
endtask
task bus(input [7:0] a, input w, input [7:0] d);
begin
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= `HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
end
endtask
task rd(input [7:0] a, input [7:0] e);
begin
    exp_q.push_back(e);
    bus(a, 1'b0, 8'h00);
end
endtask
task pause;
    repeat (8) @(posedge hclk);
endtask
task report_and_stop;
begin
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
end
endtask
// ----
// Read monitor and timeout
// ----
always @(posedge hclk)
begin
    if (rd_dp && hreadyout === 1'b1)
        chk("hrdata", exp_q.pop_front(), hrdata[7:0]);
    rd_dp <= hsel && htrans == `HTRANS_NONSEQ && !hwrite;
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
        failures = failures + 1;
        report_and_stop;
    end
end
// ----
// Stimulus
// ----
initial
begin
    {hsel, hwrite, e1, e2, t1, t2, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    seed = 78443;
    {failures, samples_checked, cycles} = '0;
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
        rd(8'(i * 4), 8'h00);
    $display("reset value test done");
    r = 8'($random(seed));
    bus(`OFS_CURRENT, 1'b1, r);
    bus(8'h10, 1'b1, ~r);
    rd(`OFS_CURRENT, r);
    rd(8'h10, 8'h00);
    pause;
    chk("current", r, {trim, rng});
    bus(`OFS_CONTROL_HIGH, 1'b1, 8'h12);
    pause;
    chk("high out", 8'h03, {6'h00, dmode, dis});
    $display("config test done");
    bus(`OFS_IRQ, 1'b1, 8'h02);
    bus(`OFS_CONTROL_HIGH, 1'b1, 8'h80);
    bus(`OFS_EDGE_LOW, 1'b1, 8'h01);
    pause;
    chk("source", 8'h01, {7'h00, src});
    bus(`OFS_EDGE_LOW, 1'b1, 8'h03);
    pause;
    chk("source", 8'h00, {7'h00, src});
    rd(`OFS_IRQ, 8'h03);
    chk("irq", 8'h01, {7'h00, irq});
    bus(`OFS_EDGE_LOW, 1'b1, 8'h00);
    bus(`OFS_IRQ, 1'b1, 8'h02);
    $display("software source test done");
    bus(`OFS_EDGE_LOW, 1'b1, 8'hB0);
    e1 <= 1'b1;
    pause;
    rd(`OFS_EDGE_LOW, 8'hB0);
    e1 <= 1'b0;
    e2 <= 1'b1;
    bus(`OFS_CONTROL_HIGH, 1'b1, 8'h8D);
    pause;
    rd(`OFS_EDGE_LOW, 8'hB0);
    e2 <= 1'b0;
    e1 <= 1'b1;
    pause;
    chk("source", 8'h01, {7'h00, src});
    e2 <= 1'b1;
    pause;
    chk("source", 8'h00, {7'h00, src});
    chk("conversions", 8'h01, convs);
    rd(`OFS_EDGE_LOW, 8'hB3);
    e1 <= 1'b0;
    e2 <= 1'b0;
    bus(`OFS_EDGE_LOW, 1'b1, 8'hB0);
    rd(`OFS_EDGE_LOW, 8'hB0);
    $display("pin edge test done");
    bus(`OFS_EDGE_LOW, 1'b1, 8'hF8);
    t1 <= 1'b1;
    pause;
    t2 <= 1'b1;
    pause;
    rd(`OFS_EDGE_LOW, 8'hFB);
    chk("conversions", 8'h02, convs);
    $display("trigger edge test done");
    bus(`OFS_CONTROL_HIGH, 1'b1, 8'h92);
    bus(`OFS_CONTROL_HIGH, 1'b1, 8'h90);
    bus(`OFS_EDGE_LOW, 1'b1, 8'h01);
    repeat (3) @(posedge hclk);
    chk("delay pulse", 8'h01, {7'h00, pulse});
    pause;
    chk("delay pulse", 8'h00, {7'h00, pulse});
    $display("delay pulse test done");
    while (exp_q.size() != 0)
        @(posedge hclk);
    report_and_stop;
end
endmodule // tb_charge_time_measure_ctrl
`default_nettype wire
